/* File: src/rx_frame_consts.svh */
// Register offsets, field positions, write masks, reset values and the largest size code for the frame receiver
`ifndef RX_FRAME_CONSTS_SVH
`define RX_FRAME_CONSTS_SVH
`define ADDR_RECEIVE_CONTROL_ONE 4'h0
`define ADDR_RECEIVE_CONTROL_TWO 4'h1
`define ADDR_RX_DATA 4'h2
`define ADDR_RX_STATUS 4'h3
`define PHASE_SEL_BIT 15
`define WORDS_MSB 14
`define WORDS_LSB 8
`define SIZE_MSB 7
`define SIZE_LSB 5
`define CONTROL_ONE_MASK 16'h7FE0
`define CONTROL_TWO_MASK 16'hFFE0
`define RESET_CONTROL 16'h0000
`define SIZE_CODE_MAX 3'h5
`endif

/* File: src/rx_frame_pkg.sv */
// Types shared by the frame receiver
`default_nettype none
package rx_frame_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_PHASE_ONE, ST_PHASE_TWO} rx_state_t;
endpackage
`default_nettype wire

/* File: src/rx_pin_sync.sv */
// Two-flop synchroniser with edge detect for the serial pins
`default_nettype none
module rx_pin_sync (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [2:0] pins_i,
   output logic [2:0] level_o,
   output logic [2:0] rise_o
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic [2:0] last_r;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
         last_r <= 3'h0;
      end else begin
         meta_r <= pins_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end
   assign level_o = sync_r;
   assign rise_o = sync_r & ~last_r;
endmodule
`default_nettype wire

/* File: src/rx_frame_phase_config.sv */
// Frame receiver with one- or two-phase frame configuration
//
// The strobed register port and the address map were left to the implementer.
`default_nettype none
`include "rx_frame_consts.svh"
module rx_frame_phase_config (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic sclk_i,
   input wire logic fsync_i,
   input wire logic sdata_i,
   output logic word_valid_o,
   output logic [31:0] word_o,
   output logic word_phase_o,
   output logic frame_done_o
);
   logic [15:0] ctl_one_r;
   logic [15:0] ctl_two_r;
   logic [15:0] rdata_r;
   logic [2:0] lvl;
   logic [2:0] rise;
   rx_frame_pkg::rx_state_t state_r;
   rx_frame_pkg::rx_state_t state_nxt;
   logic [5:0] bit_cnt_r;
   logic [5:0] bit_cnt_nxt;
   logic [6:0] word_cnt_r;
   logic [6:0] word_cnt_nxt;
   logic [31:0] shift_r;
   logic [31:0] word_r;
   logic word_valid_r;
   logic word_phase_r;
   logic frame_done_r;
   logic [7:0] frame_len_r;
   logic [7:0] last_len_r;
   logic err_size_r;

   rx_pin_sync u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .pins_i({sdata_i, fsync_i, sclk_i}),
      .level_o(lvl),
      .rise_o(rise)
   );

   // Reserved size codes fall back to 8 bits so a bad setting cannot hang a frame
   function automatic logic [5:0] size_bits(input logic [2:0] code);
      case (code)
         3'h0: size_bits = 6'h08;
         3'h1: size_bits = 6'h0C;
         3'h2: size_bits = 6'h10;
         3'h3: size_bits = 6'h14;
         3'h4: size_bits = 6'h18;
         3'h5: size_bits = 6'h20;
         default: size_bits = 6'h08;
      endcase
   endfunction

   wire dual_sel = ctl_two_r[`PHASE_SEL_BIT];
   wire [6:0] words_one = ctl_one_r[`WORDS_MSB:`WORDS_LSB];
   wire [6:0] words_two = ctl_two_r[`WORDS_MSB:`WORDS_LSB];
   wire [2:0] size_one = ctl_one_r[`SIZE_MSB:`SIZE_LSB];
   wire [2:0] size_two = ctl_two_r[`SIZE_MSB:`SIZE_LSB];
   wire in_two = (state_r == rx_frame_pkg::ST_PHASE_TWO);
   // Phase-two fields only steer the receiver in phase two
   wire [5:0] cur_bits = in_two ? size_bits(size_two) : size_bits(size_one);
   wire [6:0] cur_words = in_two ? words_two : words_one;
   // Frame length in words per sync period
   wire [7:0] frame_len = dual_sel ? ({1'b0, words_one} + {1'b0, words_two} + 8'h02)
                                   : ({1'b0, words_one} + 8'h01);
   wire sclk_rise = rise[0];
   wire fs_rise = rise[1];
   wire sbit = lvl[2];
   wire active = (state_r != rx_frame_pkg::ST_IDLE);
   // A sync edge in the same cycle wins, so that bit never completes a word
   wire last_bit = active && sclk_rise && !fs_rise && (bit_cnt_r == cur_bits - 6'h01);
   wire last_word = last_bit && (word_cnt_r == cur_words);
   wire [31:0] shifted = {shift_r[30:0], sbit};

   assign word_valid_o = word_valid_r;
   assign word_o = word_r;
   assign word_phase_o = word_phase_r;
   assign frame_done_o = frame_done_r;
   assign rdata_o = rdata_r;

   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      word_cnt_nxt = word_cnt_r;
      // A sync pulse restarts the frame; this trades resync speed for no overrun check
      if (fs_rise) begin
         state_nxt = rx_frame_pkg::ST_PHASE_ONE;
         bit_cnt_nxt = 6'h00;
         word_cnt_nxt = 7'h00;
      end else if (active && sclk_rise) begin
         bit_cnt_nxt = bit_cnt_r + 6'h01;
         if (last_bit) begin
            bit_cnt_nxt = 6'h00;
            word_cnt_nxt = word_cnt_r + 7'h01;
         end
         if (last_word) begin
            word_cnt_nxt = 7'h00;
            case (state_r)
               rx_frame_pkg::ST_PHASE_ONE: begin
                  state_nxt = dual_sel ? rx_frame_pkg::ST_PHASE_TWO
                                       : rx_frame_pkg::ST_IDLE;
               end
               default: state_nxt = rx_frame_pkg::ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= rx_frame_pkg::ST_IDLE;
         bit_cnt_r <= 6'h00;
         word_cnt_r <= 7'h00;
         shift_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         word_cnt_r <= word_cnt_nxt;
         if (fs_rise) begin
            shift_r <= 32'h0000_0000;
         end else if (active && sclk_rise) begin
            shift_r <= last_bit ? 32'h0000_0000 : shifted;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         word_valid_r <= 1'b0;
         word_r <= 32'h0000_0000;
         word_phase_r <= 1'b0;
         frame_done_r <= 1'b0;
         frame_len_r <= 8'h00;
         last_len_r <= 8'h00;
      end else begin
         word_valid_r <= last_bit;
         frame_done_r <= last_word && !(dual_sel && !in_two);
         if (last_bit) begin
            word_r <= shifted;
            word_phase_r <= in_two;
         end
         if (fs_rise) begin
            frame_len_r <= 8'h00;
         end else if (last_bit) begin
            frame_len_r <= frame_len_r + 8'h01;
         end
         if (last_word && !(dual_sel && !in_two)) begin
            last_len_r <= frame_len_r + 8'h01;
         end
      end
   end

   // Software words
   wire wr_one = wr_i && (addr_i == `ADDR_RECEIVE_CONTROL_ONE);
   wire wr_two = wr_i && (addr_i == `ADDR_RECEIVE_CONTROL_TWO);
   wire [15:0] rd_mux;
   assign rd_mux = (addr_i == `ADDR_RECEIVE_CONTROL_ONE) ? ctl_one_r :
                   (addr_i == `ADDR_RECEIVE_CONTROL_TWO) ? ctl_two_r :
                   (addr_i == `ADDR_RX_DATA) ? word_r[15:0] :
                   (addr_i == `ADDR_RX_STATUS) ?
                      {err_size_r, 3'h0, in_two, active, 2'h0, last_len_r} : 16'h0000;
   wire bad_size = (size_one > `SIZE_CODE_MAX) || (dual_sel && size_two > `SIZE_CODE_MAX);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctl_one_r <= `RESET_CONTROL;
         ctl_two_r <= `RESET_CONTROL;
         rdata_r <= 16'h0000;
         err_size_r <= 1'b0;
      end else begin
         if (wr_one) begin
            ctl_one_r <= wdata_i & `CONTROL_ONE_MASK;
         end
         if (wr_two) begin
            ctl_two_r <= wdata_i & `CONTROL_TWO_MASK;
         end
         rdata_r <= rd_i ? rd_mux : 16'h0000;
         err_size_r <= bad_size;
      end
   end

   sequence seq_phase_one_end;
      (state_r == rx_frame_pkg::ST_PHASE_ONE) && last_word && !fs_rise;
   endsequence

   AST_SINGLE_ENDS: assert property (@(posedge clk_i) disable iff (srst_i)
      seq_phase_one_end and !dual_sel |=> state_r == rx_frame_pkg::ST_IDLE)
      else $error("single phase frame did not end");
   AST_DUAL_GOES_TWO: assert property (@(posedge clk_i) disable iff (srst_i)
      seq_phase_one_end and dual_sel |=> state_r == rx_frame_pkg::ST_PHASE_TWO)
      else $error("dual phase frame skipped phase two");
   AST_TWO_NO_SYNC: assert property (@(posedge clk_i) disable iff (srst_i)
      state_r == rx_frame_pkg::ST_PHASE_TWO |-> $past(state_r) != rx_frame_pkg::ST_IDLE)
      else $error("phase two entered from idle");
   AST_NEVER_TWO_SINGLE: assert property (@(posedge clk_i) disable iff (srst_i)
      !dual_sel && $stable(dual_sel) |=> state_r != rx_frame_pkg::ST_PHASE_TWO
      || $past(state_r) == rx_frame_pkg::ST_PHASE_TWO)
      else $error("phase two used in single phase mode");
   AST_WORD_SIZE: assert property (@(posedge clk_i) disable iff (srst_i)
      last_bit && !in_two && size_one == 3'h5 |-> bit_cnt_r == 6'h1F)
      else $error("32 bit word size wrong");
   AST_SIZE_TWO: assert property (@(posedge clk_i) disable iff (srst_i)
      last_bit && in_two && size_two == 3'h0 |-> bit_cnt_r == 6'h07)
      else $error("phase two word size wrong");
   AST_COUNT_TWO: assert property (@(posedge clk_i) disable iff (srst_i)
      last_word && in_two |-> word_cnt_r == ctl_two_r[14:8])
      else $error("phase two word count wrong");
   AST_FRAME_LEN: assert property (@(posedge clk_i) disable iff (srst_i)
      frame_done_r && $stable(ctl_one_r) && $stable(ctl_two_r)
      && $past(state_r, 1) != rx_frame_pkg::ST_IDLE |-> last_len_r == frame_len)
      else $error("frame length wrong");
   AST_VALID_PULSE: assert property (@(posedge clk_i) disable iff (srst_i)
      word_valid_o |=> !word_valid_o)
      else $error("word valid longer than one cycle");
endmodule
`default_nettype wire

/* File: sim/serial_source.sv */
// Behavioural far-side serial device that sends framed words MSB first
`default_nettype none
module serial_source (
   output var logic sclk_o,
   output var logic fsync_o,
   output var logic sdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk_o = 1'b0;
      fsync_o = 1'b0;
      sdata_o = 1'b0;
   end
   // Clock runs on without a pause between words; fsync leads the first bit by a full period
   task automatic send(input logic [31:0] w, input int n, input logic sync);
      if (sync) begin
         fsync_o = 1'b1;
         #62.5;
         fsync_o = 1'b0;
      end
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o = w[i];
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      // Idle data line shows the inverse so a stale bit is never mistaken for data
      sdata_o = ~sdata_o;
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the frame receiver
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic srst_i, wr_i, rd_i, sclk, fsync, sdata, word_valid_o, word_phase_o, frame_done_o;
   logic [3:0] addr_i;
   logic [15:0] wdata_i, rdata_o, d;
   logic [31:0] word_o;
   logic [31:0] vals [8];
   int sizes [8];
   logic phs [8];
   int n_mismatch = 0, comparisons = 0, done_cnt = 0, d0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (frame_done_o === 1'b1) done_cnt <= done_cnt + 1;
   serial_source serial_source_i (.sclk_o(sclk), .fsync_o(fsync), .sdata_o(sdata));
   rx_frame_phase_config rx_frame_phase_config_i (.clk_i(clk_i), .srst_i(srst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sclk_i(sclk), .fsync_i(fsync), .sdata_i(sdata), .word_valid_o(word_valid_o),
      .word_o(word_o), .word_phase_o(word_phase_o), .frame_done_o(frame_done_o));
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // Bounded wait; a word that never arrives ends the run
   task automatic wait_word();
      for (int t = 0; t < 700; t++) begin
         @(posedge clk_i);
         #1;
         if (word_valid_o === 1'b1) return;
      end
      n_mismatch++;
      $display("[ERR] word_valid_o expected 1 seen timeout");
      close_out();
   endtask
   task automatic run_frame(input logic [15:0] c1, c2, input int n, input logic [15:0] st);
      wr(4'h0, c1);
      wr(4'h1, c2);
      d0 = done_cnt;
      fork
         begin
            // Off the clock edge so link edges never race the sampling flop
            #1;
            for (int k = 0; k < n; k++) serial_source_i.send(vals[k], sizes[k], k == 0);
         end
         for (int j = 0; j < n; j++) begin
            wait_word();
            check("word_o", word_o, vals[j]);
            check("word_phase_o", {31'h0, word_phase_o}, {31'h0, phs[j]});
         end
      join
      repeat (10) @(posedge clk_i);
      check("frame_done_count", done_cnt - d0, 1);
      rd(4'h3, d);
      check("status", {16'h0, d & 16'h80FF}, {16'h0, st});
   endtask
   task automatic reg_scn();
      rd(4'h1, d);
      check("ctl2_reset", {16'h0, d}, 32'h0);
      wr(4'h1, 16'hFFFF);
      rd(4'h1, d);
      check("ctl2_rw", {16'h0, d}, 32'hFFE0);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, d);
      check("ctl1_rw", {16'h0, d}, 32'h7FE0);
      wr(4'hF, 16'h1234);
      rd(4'hF, d);
      check("unmapped", {16'h0, d}, 32'h0);
   endtask
   task automatic single_scn();
      // Phase-two fields set to junk that must be ignored
      vals[0] = 32'hA5; vals[1] = 32'h3C; sizes[0] = 8; sizes[1] = 8;
      phs[0] = 1'b0; phs[1] = 1'b0;
      run_frame(16'h0100, 16'h05A0, 2, 16'h0002);
   endtask
   task automatic dual_scn();
      vals[0] = 32'hABC; vals[1] = 32'h80000001; vals[2] = 32'h7FFFFFFE;
      sizes[0] = 12; sizes[1] = 32; sizes[2] = 32;
      phs[0] = 1'b0; phs[1] = 1'b1; phs[2] = 1'b1;
      run_frame(16'h0020, 16'h81A0, 3, 16'h0003);
      rd(4'h2, d);
      check("rx_data", {16'h0, d}, {16'h0, vals[2][15:0]});
      // Wide phase one, narrow phase two: sizes must switch per phase
      vals[0] = 32'hFEDCBA98; vals[1] = 32'h5A; sizes[0] = 32; sizes[1] = 8;
      phs[0] = 1'b0; phs[1] = 1'b1;
      run_frame(16'h00A0, 16'h8000, 2, 16'h0002);
   endtask
   task automatic size_scn();
      int tbl [8] = '{8, 12, 16, 20, 24, 32, 8, 8};
      for (int c = 0; c < 8; c++) begin
         sizes[0] = tbl[c];
         vals[0] = 32'hB5A5C3E1 >> (32 - tbl[c]);
         phs[0] = 1'b0;
         run_frame({8'h00, c[2:0], 5'h00}, 16'h0000, 1, (c >= 6) ? 16'h8001 : 16'h0001);
      end
   endtask
   initial begin
      srst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 16'h0000;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      reg_scn();
      single_scn();
      dual_scn();
      size_scn();
      close_out();
   end
endmodule
`default_nettype wire
